// ==== rtl/ivp_top.sv ====
`timescale 1ns/10ps
module ivp_top
	import ivp_pkg::*;
(
	// Clock and reset
	input  wire logic                           clk_sys_in,
	input  wire logic                           rst_n_in,
	// Vector base from the vector_base_register
	input  wire logic [ADDR_W-1:0]              vector_base_register_in,
	// Request lines indexed by vector number, and their assigned levels
	input  wire logic [VEC_COUNT-1:0]           req_in,
	input  wire logic [VEC_COUNT-1:0][LVL_W-1:0] level_in,
	// Core handshake
	input  wire logic                           ack_in,
	output ivp_grant_t                          grant_out
);

	// Effective level of each slot, clamped to its documented range
	function automatic logic [LVL_W-1:0] eff_level(input int v, input logic [LVL_W-1:0] l);
		logic [LVL_W-1:0] r;
		r = l;
		if (VEC_FIXED3_MASK[v]) begin
			r = LVL_TOP;
		end else if (VEC_DEBUG_MASK[v]) begin
			r = (l == 2'h0) ? 2'h1 : l;
		end else if (VEC_SWI2_MASK[v]) begin
			r = 2'h2;
		end else if (VEC_SWI1_MASK[v]) begin
			r = 2'h1;
		end else if (VEC_SWI0_MASK[v]) begin
			r = 2'h0;
		end else if (l > LVL_PERIPH_MAX) begin
			r = LVL_PERIPH_MAX;
		end
		return r;
	endfunction : eff_level

	// Requests seen by the arbiter; reserved slots are masked out
	// Reset overlay entries 0 and 1 are never interrupt sources
	logic [VEC_COUNT-1:0] live_req;
	assign live_req = req_in & VEC_VALID_MASK;

	// Winner search: highest level, then smallest vector
	logic             win_found;
	logic [VEC_W-1:0] win_vec;
	logic [LVL_W-1:0] win_lvl;
	always_comb begin
		logic [LVL_W-1:0] lv;
		lv        = '0;
		win_found = 1'b0;
		win_vec   = '0;
		win_lvl   = '0;
		for (int v = 0; v < VEC_COUNT; v++) begin
			lv = eff_level(v, level_in[v]);
			// Strict greater keeps the lower vector on ties
			if (live_req[v] && (!win_found || lv > win_lvl)) begin
				win_found = 1'b1;
				win_vec   = VEC_W'(v);
				win_lvl   = lv;
			end
		end
	end

	// Vector address: base plus two words per entry, 19 bits wide
	// A carry past the top bit is dropped: table targets are 19 bits only
	logic [ADDR_W-1:0] win_addr;
	assign win_addr = vector_base_register_in
		+ (ADDR_W'(win_vec) << ENTRY_WORDS_SHIFT);

	// Grant register: loads a new winner only when none is outstanding
	ivp_grant_t grant_reg;
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			// Reset: no grant outstanding, all fields zero
			grant_reg <= '0;
		end else if (grant_reg.valid && ack_in) begin
			// Core took it: drop valid, fields keep their last value
			grant_reg.valid <= 1'b0;
		end else if (!grant_reg.valid && win_found) begin
			// Idle with a winner: vector, level and address load together
			grant_reg.valid   <= 1'b1;
			grant_reg.vector  <= win_vec;
			grant_reg.level   <= win_lvl;
			grant_reg.address <= win_addr;
		end
	end
	assign grant_out = grant_reg;

	// Snapshot of what the arbiter saw at each edge, kept for the ordering checks
	// A grant that rises at one edge was chosen from the snapshot taken at that same edge
	logic [VEC_COUNT-1:0]            req_seen_reg; // Live requests at the last edge
	logic [VEC_COUNT-1:0][LVL_W-1:0] lvl_seen_reg; // Assigned levels at the last edge

	// Request snapshot, cleared in reset so no stale slot is blamed afterwards
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			req_seen_reg <= '0; // Nothing pending in reset
		end else begin
			req_seen_reg <= live_req; // Reserved slots already masked
		end
	end

	// Level snapshot, raw as assigned; clamping is applied where it is read
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			lvl_seen_reg <= '0; // All levels zero in reset
		end else begin
			lvl_seen_reg <= level_in; // Whatever software assigned
		end
	end

	// Flags for any snapshot request that should have beaten the granted one
	logic lvl_beaten; // A pending request stood at a higher level
	logic tie_beaten; // A pending request tied on level with a smaller vector
	always_comb begin
		logic [LVL_W-1:0] sl;
		sl         = '0;
		lvl_beaten = 1'b0;
		tie_beaten = 1'b0;
		for (int v = 0; v < VEC_COUNT; v++) begin
			sl = eff_level(v, lvl_seen_reg[v]);
			// Higher level left waiting
			if (req_seen_reg[v] && sl > grant_reg.level) begin
				lvl_beaten = 1'b1;
			end
			// Same level but a smaller vector left waiting
			if (req_seen_reg[v] && sl == grant_reg.level && v < int'(grant_reg.vector)) begin
				tie_beaten = 1'b1;
			end
		end
	end

	// Handshake steps, in order: a winner ready, a grant waiting, a grant taken
	// Winner ready while no grant stands
	sequence load_s;
		!grant_reg.valid && win_found;
	endsequence
	// Grant standing, core not yet taking it
	sequence held_s;
		grant_reg.valid && !ack_in;
	endsequence
	// Grant taken by the core at this edge
	sequence taken_s;
		grant_reg.valid && ack_in;
	endsequence

	// Slot checks: only live, requested slots inside the table
	// Grant never names a reserved slot
	reserved_never_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		grant_reg.valid |-> VEC_VALID_MASK[grant_reg.vector])
		else $error("reserved vector granted");
	// Grant never names a slot past the table
	vec_range_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		grant_reg.valid |-> grant_reg.vector < VEC_W'(VEC_COUNT))
		else $error("vector out of range");
	// Granted slot was requested when the grant loaded
	slot_map_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(grant_reg.valid) |-> req_seen_reg[grant_reg.vector])
		else $error("granted slot not requested");

	// Address checks
	// Address tracks vector with two-word stride
	addr_stride_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(grant_reg.valid) |-> grant_reg.address
			== ADDR_W'($past(vector_base_register_in) + (ADDR_W'(grant_reg.vector) << 1)))
		else $error("vector address wrong");
	// Address and level hold while the grant waits
	grant_fields_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		held_s |=> $stable(grant_reg.address) && $stable(grant_reg.level))
		else $error("grant fields changed before ack");

	// Level clamps per slot class
	// Core exceptions report level 3
	exc_level_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		grant_reg.valid && VEC_FIXED3_MASK[grant_reg.vector] |-> grant_reg.level == 2'h3)
		else $error("exception level wrong");
	// Peripheral slots stay within 0..2
	periph_level_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		grant_reg.valid && grant_reg.vector >= VEC_EXT_A |-> grant_reg.level <= 2'h2)
		else $error("peripheral level too high");
	// Debug slots stay within 1..3
	debug_level_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		grant_reg.valid && VEC_DEBUG_MASK[grant_reg.vector] |-> grant_reg.level != 2'h0)
		else $error("debug level too low");

	// Ordering checks against the snapshot
	// No pending request stands at a higher level than the winner
	level_order_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(grant_reg.valid) |-> !lvl_beaten)
		else $error("level order broken");
	// Ties go to the smallest vector
	tie_order_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		$rose(grant_reg.valid) |-> !tie_beaten)
		else $error("tie order broken");

	// Handshake checks
	// A ready winner shows as a grant at the next edge
	load_next_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		load_s |=> grant_reg.valid)
		else $error("winner not granted");
	// Acknowledge drops the grant next cycle
	one_grant_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		taken_s |=> !grant_reg.valid)
		else $error("grant held after ack");
	// Grant stands stable until acknowledged
	grant_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		held_s |=> grant_reg.valid && $stable(grant_reg.vector))
		else $error("grant changed before ack");
	// Reset withdraws any grant by the next edge
	reset_clear_a: assert property (@(posedge clk_sys_in)
		!rst_n_in |=> grant_reg == '0)
		else $error("grant survived reset");

endmodule : ivp_top

// ==== inc/ivp_pkg.sv ====
package ivp_pkg;
	// Number of vector slots handled (0..41)
	localparam int VEC_COUNT = 42;
	localparam int VEC_W     = 6;
	localparam int ADDR_W    = 19;
	localparam int LVL_W     = 2;
	// Each entry spans two words
	localparam int ENTRY_WORDS_SHIFT = 1;
	// Named slots: core exceptions 2..5, then peripheral sources from 0x11
	localparam logic [VEC_W-1:0] VEC_ILLEGAL   = 6'h02;
	localparam logic [VEC_W-1:0] VEC_SWI3      = 6'h03;
	localparam logic [VEC_W-1:0] VEC_STACK_OVF = 6'h04;
	localparam logic [VEC_W-1:0] VEC_MISALIGN  = 6'h05;
	localparam logic [VEC_W-1:0] VEC_EXT_A     = 6'h11;
	localparam logic [VEC_W-1:0] VEC_LOW_VOLT  = 6'h14;
	localparam logic [VEC_W-1:0] VEC_CLK_SYNTH = 6'h15;
	localparam logic [VEC_W-1:0] VEC_FLASH_ERR = 6'h16;
	localparam logic [VEC_W-1:0] VEC_CAN_BOFF  = 6'h1A;
	localparam logic [VEC_W-1:0] VEC_SPI1_RXF  = 6'h26;
	localparam logic [VEC_W-1:0] VEC_SPI0_TXE  = 6'h29;
	// Slots never generated: resets 0,1 and reserved 8,12,13,19,25,36,37
	localparam logic [VEC_COUNT-1:0] VEC_VALID_MASK = 42'h3CF_FDF7_CEFC;
	// Slots locked at level 3 (core exceptions 2..5)
	localparam logic [VEC_COUNT-1:0] VEC_FIXED3_MASK = 42'h000_0000_003C;
	// Debug slots: level 1..3 (6,7,9,10,11)
	localparam logic [VEC_COUNT-1:0] VEC_DEBUG_MASK = 42'h000_0000_0EC0;
	// Fixed software levels at 14,15,16
	localparam logic [VEC_COUNT-1:0] VEC_SWI2_MASK = 42'h000_0000_4000;
	localparam logic [VEC_COUNT-1:0] VEC_SWI1_MASK = 42'h000_0000_8000;
	localparam logic [VEC_COUNT-1:0] VEC_SWI0_MASK = 42'h000_0001_0000;
	localparam logic [ADDR_W-1:0]    BASE_RESET    = 19'h0_0000;
	localparam logic [LVL_W-1:0]     LVL_TOP       = 2'h3;
	localparam logic [LVL_W-1:0]     LVL_PERIPH_MAX = 2'h2;
	// Grant bundle handed to the core
	typedef struct packed {
		logic              valid;
		logic [VEC_W-1:0]  vector;
		logic [LVL_W-1:0]  level;
		logic [ADDR_W-1:0] address;
	} ivp_grant_t;
endpackage : ivp_pkg

// ==== dv/ivp_core_model.sv ====
`timescale 1ns/10ps
// Core side: takes a held grant after one or three falling edges
module ivp_core_model
	import ivp_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	// Grant and pacing
	input  ivp_grant_t grant_in,
	input  wire logic  slow_in,
	// Acknowledge, and whether the fetched entry holds a subroutine call
	output logic       ack_out = 1'b0,
	output logic       fetch_call_out = 1'b0
);
	logic [1:0] wait_reg = 2'h0; // Falling edges seen since the grant rose
	// Table as software lays it out: plain jumps in entries 0 and 1, subroutine calls elsewhere
	function automatic logic entry_is_call(input logic [VEC_W-1:0] vec);
		return vec > 6'h01;
	endfunction : entry_is_call
	// One-cycle acknowledge pulse, then idle until the next grant
	always @(negedge clk_sys_in) begin
		if (!rst_n_in || grant_in.valid !== 1'b1 || ack_out) begin
			ack_out  <= 1'b0;
			wait_reg <= 2'h0;
		end else if (wait_reg == (slow_in ? 2'h2 : 2'h0)) begin
			ack_out        <= 1'b1;
			fetch_call_out <= entry_is_call(grant_in.vector); // Entry fetched as the grant is taken
		end else begin
			wait_reg <= wait_reg + 2'h1;
		end
	end
endmodule : ivp_core_model

// ==== dv/tb_interrupt_vector_priority.sv ====
`timescale 1ns/10ps
`define CHK(w,e,s) begin checks++; if ((s)!==(e)) begin miscompares++; $display("mismatch %s exp %0h got %0h",w,e,s); end end
module tb_interrupt_vector_priority import ivp_pkg::*;;
	logic                             clk_sys_in = 1'b0;
	logic                             rst_n_in   = 1'b0;
	logic                             ack, fetch, slow = 1'b0;
	logic [ADDR_W-1:0]                base = '0, ea;
	logic [VEC_COUNT-1:0]             req = '0;
	logic [VEC_COUNT-1:0][LVL_W-1:0]  lvl = '0;
	logic [VEC_W-1:0]                 ev;
	logic [LVL_W-1:0]                 el;
	logic [31:0]                      rnd = 32'h0000_5862;
	ivp_grant_t                       grant;
	int                               checks = 0, miscompares = 0, n;
	// Clock of 10 ns
	initial forever #5 clk_sys_in = ~clk_sys_in;
	ivp_top DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .vector_base_register_in(base),
		.req_in(req), .level_in(lvl), .ack_in(ack), .grant_out(grant));
	ivp_core_model CORE (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .grant_in(grant),
		.slow_in(slow), .ack_out(ack), .fetch_call_out(fetch));
	// Repeatable xorshift source
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	// Expected winner from the live requests and clamped levels
	function automatic void pick();
		logic [1:0] c;
		logic       f;
		f = 1'b0;
		for (int v = 0; v < VEC_COUNT; v++) if (req[v] && VEC_VALID_MASK[v]) begin
			c = VEC_FIXED3_MASK[v] ? 2'h3 : VEC_SWI2_MASK[v] ? 2'h2 : VEC_SWI1_MASK[v] ? 2'h1 :
				VEC_SWI0_MASK[v] ? 2'h0 : (VEC_DEBUG_MASK[v] && lvl[v] == 2'h0) ? 2'h1 :
				(v >= 17 && lvl[v] == 2'h3) ? 2'h2 : lvl[v];
			if (!f || c > el) begin
				f  = 1'b1;
				el = c;
				ev = v[VEC_W-1:0];
			end
		end
	endfunction : pick
	// Counts, verdict and end of run
	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	// Watchdog against a hung handshake
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
	// Main sequence: reset, then random and corner grants
	initial begin
		repeat (16) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		for (int t = 0; t < 40; t++) begin
			rnd  = xs(rnd);
			base = rnd[18:0];
			slow = rnd[19];
			rnd  = xs(rnd);
			req  = {rnd[9:0], xs(rnd)};
			for (int v = 0; v < VEC_COUNT; v++) begin
				rnd    = xs(rnd);
				lvl[v] = rnd[1:0];
			end
			if (t % 4 == 1) req = req & ~42'h000_0000_0FFC; // No core or debug slots: peripherals contend
			if (t % 4 == 2) req = req & ~42'h000_0000_003C; // No core exceptions: debug levels contend
			if (t == 0) req = '1; // All pending: exception 2 wins
			if (t == 1) req = 42'h230_0208_3103; // Reserved slots plus the last one
			pick();
			ea = base + {ev, 1'b0};
			n  = 0;
			while (grant.valid !== 1'b1 && n < 20) begin
				@(negedge clk_sys_in);
				n++;
			end
			`CHK("latency", 1, n)
			`CHK("vector", ev, grant.vector)
			`CHK("level", el, grant.level)
			`CHK("address", ea, grant.address)
			if (t == 20) begin // Reset in mid-run while the grant is outstanding
				rst_n_in = 1'b0;
				repeat (2) @(negedge clk_sys_in);
				`CHK("reset", 0, grant)
				rst_n_in = 1'b1;
			end
			while (grant.valid !== 1'b0 && n < 40) begin
				@(negedge clk_sys_in);
				n++;
			end
			`CHK("release", 0, grant.valid)
			`CHK("entry kind", 1, fetch)
			$display("test %0d done", t);
		end
		conclude();
	end
endmodule : tb_interrupt_vector_priority
